//--- hw/spc_pkg.sv
// package: register map, field layout, baud scales and carrier types of the serial port
package spc_pkg;

	// register byte addresses on the bus
	localparam logic [31:0] SPC_OFF_TX_CTRL  = 32'h0000_0000;
	localparam logic [31:0] SPC_OFF_RX_CTRL  = 32'h0000_0004;
	localparam logic [31:0] SPC_OFF_BAUD_DIV = 32'h0000_0008;
	localparam logic [31:0] SPC_OFF_RX_DATA  = 32'h0000_000C;
	localparam logic [31:0] SPC_OFF_TX_DATA  = 32'h0000_0010;

	// transmit_control_status fields
	localparam int F_CLOCK_SOURCE_SELECT  = 7;
	localparam int F_TX_NINE_BIT_SELECT   = 6;
	localparam int F_TRANSMIT_ENABLE_BIT  = 5;
	localparam int F_SYNC_MODE            = 4;
	localparam int F_HIGH_SPEED_SELECT    = 2;
	localparam int F_TX_SHIFT_EMPTY       = 1;
	localparam int F_TX_NINTH_BIT         = 0;

	// receive_control_status fields
	localparam int F_PORT_ENABLE          = 7;
	localparam int F_RX_NINE_BIT_SELECT   = 6;
	localparam int F_SINGLE_RECEIVE       = 5;
	localparam int F_CONTINUOUS_RECEIVE   = 4;
	localparam int F_ADDRESS_DETECT       = 3;
	localparam int F_FRAMING_ERROR_FLAG   = 2;
	localparam int F_OVERRUN_ERROR_FLAG   = 1;
	localparam int F_RX_NINTH_BIT         = 0;

	// reset values and software-writable masks
	localparam logic [7:0] SPC_TX_CTRL_RST  = 8'h02;
	localparam logic [7:0] SPC_RX_CTRL_RST  = 8'h00;
	localparam logic [7:0] SPC_BAUD_RST     = 8'h00;
	localparam logic [7:0] SPC_TX_CTRL_WMSK = 8'hF5;
	localparam logic [7:0] SPC_RX_CTRL_WMSK = 8'hF8;

	// baud multipliers and character lengths
	localparam logic [6:0] SPC_MULT_LOW  = 7'h40;
	localparam logic [6:0] SPC_MULT_HIGH = 7'h10;
	localparam logic [6:0] SPC_MULT_SYNC = 7'h04;
	localparam logic [3:0] SPC_BITS_8    = 4'h8;
	localparam logic [3:0] SPC_BITS_9    = 4'h9;

	// bus responses
	localparam logic [1:0] SPC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {REG_TX_CTRL, REG_RX_CTRL, REG_BAUD_DIV, REG_RX_DATA, REG_TX_DATA,
		REG_NONE} spc_reg_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} spc_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spc_rx_state_t;

	// bus master to slave
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} spc_axi_req_t;

	// bus slave to master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} spc_axi_rsp_t;

	// baud timer state
	typedef struct packed {
		logic [7:0] div_cnt;
		logic [6:0] scale_cnt;
	} spc_baud_state_t;

	// register address decode, shared by read and write paths
	function automatic spc_reg_t spc_decode(input logic [31:0] addr);
		case (addr)
			SPC_OFF_TX_CTRL:  spc_decode = REG_TX_CTRL;
			SPC_OFF_RX_CTRL:  spc_decode = REG_RX_CTRL;
			SPC_OFF_BAUD_DIV: spc_decode = REG_BAUD_DIV;
			SPC_OFF_RX_DATA:  spc_decode = REG_RX_DATA;
			SPC_OFF_TX_DATA:  spc_decode = REG_TX_DATA;
			default:          spc_decode = REG_NONE;
		endcase
	endfunction

endpackage

//--- hw/spc_baud_timer.sv
// baud timer: divides the clock by divisor+1, then by the mode multiplier
`timescale 1ns/1ps
`default_nettype none
module spc_baud_timer
	import spc_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// control
	input  wire logic       clear,
	input  wire logic [7:0] divisor,
	input  wire logic [6:0] mult,
	// timing strobes
	output logic            sub_tick,
	output logic            half_tick,
	output logic            bit_tick
);
	spc_baud_state_t st_q;
	spc_baud_state_t st_d;

	// free-running divide, restarted at once by clear
	always_comb begin
		st_d      = st_q;
		sub_tick  = !clear && (st_q.div_cnt == divisor);
		half_tick = sub_tick && (st_q.scale_cnt == (mult >> 1) - 7'h01);
		bit_tick  = sub_tick && (st_q.scale_cnt >= mult - 7'h01);
		if (clear) begin
			st_d = '0;
		end else if (sub_tick) begin
			st_d.div_cnt   = 8'h00;
			st_d.scale_cnt = bit_tick ? 7'h00 : st_q.scale_cnt + 7'h01;
		end else begin
			st_d.div_cnt = st_q.div_cnt + 8'h01;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_clear_quiet;
		clear ##1 (divisor != 8'h00) |-> !sub_tick;
	endproperty
	a_clear_quiet: assert property (p_clear_quiet) else $error("tick right after clear");

	property p_bit_on_sub;
		bit_tick |-> (sub_tick && half_tick == (mult == 7'h02));
	endproperty
	a_bit_on_sub: assert property (p_bit_on_sub) else $error("bit tick off its sub tick");
endmodule
`default_nettype wire

//--- hw/spc_serial_port.sv
// serial port: bus registers, baud control, transmit and receive shifters, two-entry buffer
`timescale 1ns/1ps
`default_nettype none

typedef struct packed {
	logic [7:0]      tx_ctrl;
	logic [7:0]      rx_ctrl;
	logic [7:0]      baud;
	logic            aw_got;
	logic [31:0]     aw_addr;
	logic            w_got;
	logic [31:0]     w_data;
	logic [3:0]      w_strb;
	logic            bvalid;
	logic [1:0]      bresp;
	logic            rvalid;
	logic [31:0]     rdata;
	logic [1:0]      rresp;
	spc_pkg::spc_tx_state_t tx_st;
	logic [8:0]      transmit_shift_register;
	logic [3:0]      tx_cnt;
	logic            line;
	logic            ck_lvl;
	spc_pkg::spc_rx_state_t rx_st;
	logic [8:0]      receive_shift_register;
	logic [3:0]      rx_cnt;
	logic [6:0]      rx_sub;
	logic [1:0][9:0] fifo;
	logic [1:0]      fcnt;
	logic            ck_prev;
	logic            dt_o;
	logic            dt_oe_n;
	logic            ck_o;
	logic            ck_oe_n;
} spc_port_state_t;

// Summary of operation
// - sync mode: clock select 1 makes the clock from baud timer, 0 takes it in
// - transmit nine-bit select sends nine-bit characters, else eight
// - transmit enable gates sending; in sync mode receive enables win over it
// - mode bit: 1 synchronous, 0 asynchronous
// - high speed select picks 16 or 64 multiplier, ignored in sync mode
// - shift-empty flag reads 1 when transmit shifter is empty, 1 after reset
// - transmit ninth bit is sent as the ninth bit, no computation
// - port enable hands pins to the port; cleared holds the port in reset
// - receive nine-bit select shifts nine-bit characters, else eight
// - single receive takes one character in sync master, then clears itself
// - continuous receive enables receiver; in sync mode it wins over single receive
// - async nine-bit address detect keeps only characters whose ninth bit is 1
// - framing flag follows the oldest unread character, moving on each read
// - overrun flag clears when continuous receive is cleared
// - received ninth bit is presented as is, no parity check
// - port drives or releases pins itself; direction bits stay as inputs
// - dedicated free-running eight-bit timer makes baud timing for both modes
// - rate is clock over divisor+1 times 64, 16, or 4 in sync
// - writing the divisor clears the baud timer at once
// - buffer holds two characters; a third sets overrun and stops reception
module spc_serial_port
	import spc_pkg::*;
(
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// register bus
	input  wire spc_axi_req_t axi_req,
	output spc_axi_rsp_t      axi_rsp,
	// receive/data pin
	input  wire logic         dt_i,
	output logic              dt_o,
	output logic              dt_oe_n,
	// transmit/clock pin
	input  wire logic         ck_i,
	output logic              ck_o,
	output logic              ck_oe_n
);
	spc_port_state_t st_q;
	spc_port_state_t st_d;

	logic       port_en;
	logic       sync_mode;
	logic       master;
	logic [6:0] mult;
	logic       do_wr;
	spc_reg_t   wr_reg;
	logic       baud_clr;
	logic       sub_tick;
	logic       half_tick;
	logic       bit_tick;
	logic       rx_push;
	logic       ov_set;
	logic       single_done;
	logic       tx_start;
	logic       tx_load;
	logic [9:0] rx_entry;

	// mode decode from the control registers
	assign port_en   = st_q.rx_ctrl[F_PORT_ENABLE];
	assign sync_mode = st_q.tx_ctrl[F_SYNC_MODE];
	assign master    = sync_mode && st_q.tx_ctrl[F_CLOCK_SOURCE_SELECT];
	assign mult      = sync_mode ? SPC_MULT_SYNC :
		(st_q.tx_ctrl[F_HIGH_SPEED_SELECT] ? SPC_MULT_HIGH : SPC_MULT_LOW);

	// a write is carried out once address and data are both held
	assign do_wr    = st_q.aw_got && st_q.w_got && !st_q.bvalid;
	assign wr_reg   = spc_decode(st_q.aw_addr);
	assign baud_clr = !port_en || (do_wr && wr_reg == REG_BAUD_DIV && st_q.w_strb[0]);

	// bus handshakes, data from flops
	assign axi_rsp.awready = !st_q.aw_got && !st_q.bvalid;
	assign axi_rsp.wready  = !st_q.w_got && !st_q.bvalid;
	assign axi_rsp.bvalid  = st_q.bvalid;
	assign axi_rsp.bresp   = st_q.bresp;
	assign axi_rsp.arready = !st_q.rvalid;
	assign axi_rsp.rvalid  = st_q.rvalid;
	assign axi_rsp.rdata   = st_q.rdata;
	assign axi_rsp.rresp   = st_q.rresp;

	// pins come straight from flops
	assign dt_o    = st_q.dt_o;
	assign dt_oe_n = st_q.dt_oe_n;
	assign ck_o    = st_q.ck_o;
	assign ck_oe_n = st_q.ck_oe_n;

	spc_baud_timer u_baud (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.clear     (baud_clr),
		.divisor   (st_q.baud),
		.mult      (mult),
		.sub_tick  (sub_tick),
		.half_tick (half_tick),
		.bit_tick  (bit_tick)
	);

	// next-state logic of the whole port
	always_comb begin
		logic       rx_run;
		logic       tx_run;
		logic       ck_rise;
		logic       ck_fall;
		logic       samp;
		logic       shft;
		logic       pop;
		logic       rx_done;
		logic       framing_error_flag;
		logic       rx_ok;
		logic [3:0] tbits;
		logic [3:0] rbits;
		logic [1:0] cnt;
		spc_reg_t   rd_reg;
		rx_run      = 1'b0;
		tx_run      = 1'b0;
		ck_rise     = 1'b0;
		ck_fall     = 1'b0;
		samp        = 1'b0;
		shft        = 1'b0;
		pop         = 1'b0;
		rx_done     = 1'b0;
		framing_error_flag        = 1'b0;
		rx_ok       = 1'b0;
		tbits       = SPC_BITS_8;
		rbits       = SPC_BITS_8;
		cnt         = 2'h0;
		rd_reg      = spc_decode(axi_req.araddr);
		st_d        = st_q;
		rx_push     = 1'b0;
		ov_set      = 1'b0;
		single_done = 1'b0;
		tx_start    = 1'b0;
		tx_load     = 1'b0;
		rx_entry    = 10'h000;

		tbits   = st_q.tx_ctrl[F_TX_NINE_BIT_SELECT] ? SPC_BITS_9 : SPC_BITS_8;
		rbits   = st_q.rx_ctrl[F_RX_NINE_BIT_SELECT] ? SPC_BITS_9 : SPC_BITS_8;
		ck_rise = ck_i && !st_q.ck_prev;
		ck_fall = !ck_i && st_q.ck_prev;
		st_d.ck_prev = ck_i;
		// continuous receive wins over single; single only as sync master
		rx_run = st_q.rx_ctrl[F_CONTINUOUS_RECEIVE] ||
			(master && st_q.rx_ctrl[F_SINGLE_RECEIVE]);
		rx_ok  = port_en && rx_run && !st_q.rx_ctrl[F_OVERRUN_ERROR_FLAG];
		tx_run = port_en && st_q.tx_ctrl[F_TRANSMIT_ENABLE_BIT] &&
			!(sync_mode && (st_q.rx_ctrl[F_SINGLE_RECEIVE] ||
			st_q.rx_ctrl[F_CONTINUOUS_RECEIVE]));
		// master samples on the clock's rise, slave on the partner's
		samp = master ? half_tick : ck_rise;
		shft = master ? bit_tick : ck_fall;

		// write channel capture, in either order
		if (axi_req.awvalid && !st_q.aw_got && !st_q.bvalid) begin
			st_d.aw_got  = 1'b1;
			st_d.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !st_q.w_got && !st_q.bvalid) begin
			st_d.w_got  = 1'b1;
			st_d.w_data = axi_req.wdata;
			st_d.w_strb = axi_req.wstrb;
		end
		if (st_q.bvalid && axi_req.bready) begin
			st_d.bvalid = 1'b0;
		end

		// read channel: answer from flops, reading received data pops it
		if (st_q.rvalid && axi_req.rready) begin
			st_d.rvalid = 1'b0;
		end
		if (axi_req.arvalid && !st_q.rvalid) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = SPC_RESP_OKAY;
			st_d.rdata  = 32'h0000_0000;
			case (rd_reg)
				REG_TX_CTRL:  st_d.rdata[7:0] = st_q.tx_ctrl;
				REG_RX_CTRL:  st_d.rdata[7:0] = {st_q.rx_ctrl[7:3],
					st_q.fcnt != 2'h0 && st_q.fifo[0][9],
					st_q.rx_ctrl[F_OVERRUN_ERROR_FLAG],
					st_q.fcnt != 2'h0 && st_q.fifo[0][8]};
				REG_BAUD_DIV: st_d.rdata[7:0] = st_q.baud;
				REG_RX_DATA: begin
					st_d.rdata[7:0] = (st_q.fcnt != 2'h0) ? st_q.fifo[0][7:0] : 8'h00;
					pop             = st_q.fcnt != 2'h0;
				end
				REG_TX_DATA:  st_d.rdata = 32'h0000_0000;
				default:      st_d.rresp = SPC_RESP_SLVERR;
			endcase
		end

		// transmit shifter
		case (st_q.tx_st)
			TX_IDLE: begin
				if (!st_q.tx_ctrl[F_TX_SHIFT_EMPTY] && tx_run) begin
					if (sync_mode) begin
						tx_start    = 1'b1;
						st_d.tx_st  = TX_DATA;
						st_d.line   = st_q.transmit_shift_register[0];
						st_d.tx_cnt = 4'h0;
					end else if (bit_tick) begin
						tx_start   = 1'b1;
						st_d.tx_st = TX_START;
						st_d.line  = 1'b0;
					end
				end
			end
			TX_START: begin
				if (bit_tick) begin
					st_d.tx_st  = TX_DATA;
					st_d.line   = st_q.transmit_shift_register[0];
					st_d.tx_cnt = 4'h0;
				end
			end
			TX_DATA: begin
				if (sync_mode ? shft : bit_tick) begin
					if (st_q.tx_cnt == tbits - 4'h1) begin
						st_d.line = 1'b1;
						if (sync_mode) begin
							st_d.tx_st = TX_IDLE;
							st_d.tx_ctrl[F_TX_SHIFT_EMPTY] = 1'b1;
						end else begin
							st_d.tx_st = TX_STOP;
						end
					end else begin
						st_d.tx_cnt = st_q.tx_cnt + 4'h1;
						st_d.transmit_shift_register    = {1'b0, st_q.transmit_shift_register[8:1]};
						st_d.line   = st_q.transmit_shift_register[1];
					end
				end
			end
			TX_STOP: begin
				if (bit_tick) begin
					st_d.tx_st = TX_IDLE;
					st_d.tx_ctrl[F_TX_SHIFT_EMPTY] = 1'b1;
				end
			end
			default: st_d.tx_st = TX_IDLE;
		endcase

		// master clock runs only while a character moves
		if (master && (st_q.tx_st == TX_DATA || rx_ok)) begin
			if (half_tick) begin
				st_d.ck_lvl = 1'b1;
			end else if (bit_tick) begin
				st_d.ck_lvl = 1'b0;
			end
		end else begin
			st_d.ck_lvl = 1'b0;
		end

		// receive shifter
		if (sync_mode) begin
			st_d.rx_st = RX_IDLE;
			if (!rx_ok) begin
				st_d.rx_cnt = 4'h0;                                               // no count left over from async
			end
			if (rx_ok && samp) begin
				st_d.receive_shift_register[st_q.rx_cnt] = dt_i;
				if (st_q.rx_cnt == rbits - 4'h1) begin
					st_d.rx_cnt = 4'h0;
					rx_done     = 1'b1;
					single_done = !st_q.rx_ctrl[F_CONTINUOUS_RECEIVE];
				end else begin
					st_d.rx_cnt = st_q.rx_cnt + 4'h1;
				end
			end
		end else if (!rx_ok) begin
			st_d.rx_st = RX_IDLE;
		end else begin
			case (st_q.rx_st)
				RX_IDLE: begin
					if (!dt_i) begin
						st_d.rx_st  = RX_START;
						st_d.rx_sub = 7'h00;
					end
				end
				RX_START: begin
					if (sub_tick) begin
						st_d.rx_sub = st_q.rx_sub + 7'h01;
						if (st_q.rx_sub == (mult >> 1) - 7'h01) begin
							st_d.rx_st  = dt_i ? RX_IDLE : RX_DATA;
							st_d.rx_sub = 7'h00;
							st_d.rx_cnt = 4'h0;
						end
					end
				end
				RX_DATA, RX_STOP: begin
					if (sub_tick) begin
						st_d.rx_sub = st_q.rx_sub + 7'h01;
						if (st_q.rx_sub == mult - 7'h01) begin
							st_d.rx_sub = 7'h00;
							if (st_q.rx_st == RX_STOP) begin
								st_d.rx_st = RX_IDLE;
								rx_done    = 1'b1;
								framing_error_flag       = !dt_i;
							end else begin
								st_d.receive_shift_register[st_q.rx_cnt] = dt_i;
								st_d.rx_cnt           = st_q.rx_cnt + 4'h1;
								if (st_q.rx_cnt == rbits - 4'h1) begin
									st_d.rx_st = RX_STOP;
								end
							end
						end
					end
				end
				default: st_d.rx_st = RX_IDLE;
			endcase
		end

		// two-entry buffer: pop first, then push or flag overrun
		rx_entry = {framing_error_flag, st_q.rx_ctrl[F_RX_NINE_BIT_SELECT] && st_d.receive_shift_register[8], st_d.receive_shift_register[7:0]};
		cnt      = st_q.fcnt;
		if (pop) begin
			st_d.fifo[0] = st_q.fifo[1];
			cnt          = cnt - 2'h1;
		end
		// address detect only filters asynchronous nine-bit reception
		if (rx_done && !(!sync_mode && st_q.rx_ctrl[F_RX_NINE_BIT_SELECT] &&
			st_q.rx_ctrl[F_ADDRESS_DETECT] && !rx_entry[8])) begin
			if (cnt == 2'h2) begin
				ov_set = 1'b1;
			end else begin
				rx_push           = 1'b1;
				st_d.fifo[cnt[0]] = rx_entry;
				cnt               = cnt + 2'h1;
			end
		end
		st_d.fcnt = cnt;
		if (single_done) begin
			st_d.rx_ctrl[F_SINGLE_RECEIVE] = 1'b0;
		end

		// register writes; a software write to the receive control wins
		if (do_wr) begin
			st_d.aw_got = 1'b0;
			st_d.w_got  = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp  = (wr_reg == REG_NONE) ? SPC_RESP_SLVERR : SPC_RESP_OKAY;
			if (st_q.w_strb[0]) begin
				case (wr_reg)
					REG_TX_CTRL:  st_d.tx_ctrl = (st_d.tx_ctrl & ~SPC_TX_CTRL_WMSK) |
						(st_q.w_data[7:0] & SPC_TX_CTRL_WMSK);
					REG_RX_CTRL: begin
						st_d.rx_ctrl = (st_d.rx_ctrl & ~SPC_RX_CTRL_WMSK) |
							(st_q.w_data[7:0] & SPC_RX_CTRL_WMSK);
						if (!st_q.w_data[F_CONTINUOUS_RECEIVE]) begin
							st_d.rx_ctrl[F_OVERRUN_ERROR_FLAG] = 1'b0;
						end
					end
					REG_BAUD_DIV: st_d.baud = st_q.w_data[7:0];
					REG_TX_DATA: begin
						if (tx_run && st_q.tx_ctrl[F_TX_SHIFT_EMPTY] &&
							st_q.tx_st == TX_IDLE) begin
							tx_load  = 1'b1;
							st_d.transmit_shift_register = {st_q.tx_ctrl[F_TX_NINTH_BIT], st_q.w_data[7:0]};
							st_d.tx_ctrl[F_TX_SHIFT_EMPTY] = 1'b0;
						end
					end
					default: st_d.baud = st_q.baud;
				endcase
			end
		end
		// a new overrun wins over a clear in the same cycle
		if (ov_set) begin
			st_d.rx_ctrl[F_OVERRUN_ERROR_FLAG] = 1'b1;
		end

		// disabled port is held in reset with both pins released
		if (!port_en) begin
			st_d.tx_st   = TX_IDLE;
			st_d.rx_st   = RX_IDLE;
			st_d.rx_cnt  = 4'h0;
			st_d.fcnt    = 2'h0;
			st_d.fifo    = '0;
			st_d.line    = 1'b1;
			st_d.ck_lvl  = 1'b0;
			st_d.tx_ctrl[F_TX_SHIFT_EMPTY]     = 1'b1;
			st_d.rx_ctrl[F_OVERRUN_ERROR_FLAG] = 1'b0;
		end
		// pin steering: async drives transmit line, sync drives data only when sending
		st_d.ck_oe_n = !(port_en && (!sync_mode || master));
		st_d.ck_o    = sync_mode ? st_d.ck_lvl : st_d.line;
		st_d.dt_oe_n = !(port_en && sync_mode && st_d.tx_st == TX_DATA);
		st_d.dt_o    = st_d.line;
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q         <= '0;
			st_q.tx_ctrl <= SPC_TX_CTRL_RST;
			st_q.rx_ctrl <= SPC_RX_CTRL_RST;
			st_q.baud    <= SPC_BAUD_RST;
			st_q.line    <= 1'b1;
			st_q.dt_oe_n <= 1'b1;
			st_q.ck_oe_n <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_empty_when_off;
		!port_en |=> st_q.tx_ctrl[F_TX_SHIFT_EMPTY];
	endproperty
	a_empty_when_off: assert property (p_empty_when_off) else $error("shifter busy while off");

	property p_pins_released;
		!port_en |=> (dt_oe_n && ck_oe_n);
	endproperty
	a_pins_released: assert property (p_pins_released) else $error("pin driven while off");

	property p_fifo_bound;
		st_q.fcnt <= 2'h2;
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("buffer above two entries");

	property p_no_push_overrun;
		st_q.rx_ctrl[F_OVERRUN_ERROR_FLAG] |-> !rx_push;
	endproperty
	a_no_push_overrun: assert property (p_no_push_overrun) else $error("push during overrun");

	property p_addr_filter;
		(rx_push && !sync_mode && st_q.rx_ctrl[F_RX_NINE_BIT_SELECT] &&
			st_q.rx_ctrl[F_ADDRESS_DETECT]) |-> rx_entry[8];
	endproperty
	a_addr_filter: assert property (p_addr_filter) else $error("data kept in address mode");

	property p_overrun_clear;
		(do_wr && wr_reg == REG_RX_CTRL && st_q.w_strb[0] &&
			!st_q.w_data[F_CONTINUOUS_RECEIVE] && !ov_set)
			|=> !st_q.rx_ctrl[F_OVERRUN_ERROR_FLAG];
	endproperty
	a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");

	property p_single_clear;
		(single_done && !(do_wr && wr_reg == REG_RX_CTRL)) |=> !st_q.rx_ctrl[F_SINGLE_RECEIVE];
	endproperty
	a_single_clear: assert property (p_single_clear) else $error("single receive stuck");

	property p_rx_priority;
		(sync_mode && (st_q.rx_ctrl[F_SINGLE_RECEIVE] || st_q.rx_ctrl[F_CONTINUOUS_RECEIVE]))
			|-> !tx_start;
	endproperty
	a_rx_priority: assert property (p_rx_priority) else $error("send began while receiving");

	property p_ninth_loaded;
		tx_load |=> st_q.transmit_shift_register[8] == $past(st_q.tx_ctrl[F_TX_NINTH_BIT]) && !st_q.tx_ctrl[1];
	endproperty
	a_ninth_loaded: assert property (p_ninth_loaded) else $error("ninth bit not loaded");
endmodule
`default_nettype wire

//--- test/spc_line_partner.sv
// serial line partner: drives asynchronous frames to the port and samples what it sends
`timescale 1ns/1ps
`default_nettype none
module spc_line_partner (
	// clock
	input  wire logic aclk,
	// port's transmit line, idle high
	input  wire logic tx_i,
	// line toward the port, idle high
	output logic      line_o
);
	initial line_o = 1'b1;
	// start, data lsb first, ninth bit if asked, stop (0 for a bad frame), then idle
	task automatic send(input logic [8:0] d, input logic n9, stp, input int bt);
		logic [10:0] f;
		f = n9 ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
		for (int i = 0; i < (n9 ? 11 : 10); i++) begin
			@(posedge aclk);
			line_o <= f[i];
			repeat (bt - 1) @(posedge aclk);
		end
		@(posedge aclk);
		line_o <= 1'b1;
	endtask
	// wait for a start bit, then sample eight data bits and the stop bit at bit centres
	task automatic recv(input int bt, output logic [8:0] d);
		do @(posedge aclk); while (tx_i !== 1'b0);
		repeat (bt / 2) @(posedge aclk);
		for (int i = 0; i < 9; i++) begin
			repeat (bt) @(posedge aclk);
			d[i] = tx_i;
		end
	endtask
endmodule
`default_nettype wire

//--- test/test_spc_serial_port.sv
// testbench: registers, receive flags and transmit timing of the serial port
`timescale 1ns/1ps
`default_nettype none
module test_spc_serial_port;
	import spc_pkg::*;
	localparam logic [31:0] TXC = SPC_OFF_TX_CTRL;
	localparam logic [31:0] RXC = SPC_OFF_RX_CTRL;
	localparam logic [31:0] BDV = SPC_OFF_BAUD_DIV;
	localparam logic [31:0] RXD = SPC_OFF_RX_DATA;
	localparam logic [31:0] BAD = 32'h0000_0020;
	logic         aclk;
	logic         aresetn;
	spc_axi_req_t req;
	spc_axi_rsp_t rsp;
	logic [8:0]   rb;
	logic         dt_i, dt_o, dt_oe_n, ck_o, ck_oe_n;
	int           err_total = 0;
	int           checked = 0;
	int           cyc = 0;

	spc_serial_port u_spc_serial_port (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
		.axi_rsp(rsp), .dt_i(dt_i), .dt_o(dt_o), .dt_oe_n(dt_oe_n), .ck_i(1'b0),
		.ck_o(ck_o), .ck_oe_n(ck_oe_n));
	spc_line_partner u_spc_line_partner (.aclk(aclk), .tx_i(ck_o), .line_o(dt_i));

	// 200 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic tally_and_finish;
		if (err_total == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// bus write: address and data offered together, each released when taken
	task automatic wr(input logic [31:0] a, input logic [7:0] d,
		input logic [1:0] er = SPC_RESP_OKAY);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= 32'(d);
		req.wstrb   <= 4'hF;
		req.bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		chk(32'(rsp.bresp), 32'(er));
	endtask

	// bus read with data and response compare
	task automatic rc(input logic [31:0] a, input logic [7:0] e,
		input logic [1:0] er = SPC_RESP_OKAY);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
		chk(rsp.rdata, 32'(e));
		chk(32'(rsp.rresp), 32'(er));
	endtask

	// one received frame at 16 clocks a bit, then status and data
	task automatic rx_case(input logic [8:0] d, input logic n9, stp, input logic [7:0] ce, de);
		u_spc_line_partner.send(d, n9, stp, 16);
		repeat (20) @(posedge aclk);
		rc(RXC, ce);
		rc(RXD, de);
	endtask

	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish;
		end
	end

	// main sequence
	initial begin
		aresetn = 1'b0;
		req     = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rc(TXC, 8'h02);
		rc(RXC, 8'h00);
		rc(BDV, 8'h00);
		chk(32'(ck_oe_n), 32'h1);
		wr(TXC, 8'hFF);
		rc(TXC, 8'hF7);
		wr(BAD, 8'h55, SPC_RESP_SLVERR);
		rc(BAD, 8'h00, SPC_RESP_SLVERR);
		wr(TXC, 8'h24);
		wr(BDV, 8'h00);
		wr(RXC, 8'h90);
		@(negedge aclk);
		chk(32'(ck_oe_n), 32'h0);
		chk(32'(dt_oe_n), 32'h1);
		rx_case(9'h0C3, 1'b0, 1'b0, 8'h94, 8'hC3);
		rx_case(9'h0A5, 1'b0, 1'b1, 8'h90, 8'hA5);
		wr(RXC, 8'hD0);
		rx_case(9'h15A, 1'b1, 1'b1, 8'hD1, 8'h5A);
		wr(RXC, 8'hD8);
		u_spc_line_partner.send(9'h033, 1'b1, 1'b1, 16);
		rx_case(9'h144, 1'b1, 1'b1, 8'hD9, 8'h44);
		rc(RXD, 8'h00);
		wr(RXC, 8'h90);
		u_spc_line_partner.send(9'h011, 1'b0, 1'b1, 16);
		u_spc_line_partner.send(9'h022, 1'b0, 1'b1, 16);
		rx_case(9'h033, 1'b0, 1'b1, 8'h92, 8'h11);
		wr(RXC, 8'h80);
		rc(RXC, 8'h80);
		rc(RXD, 8'h22);
		// low speed, divisor 1: 128 clocks a bit, ten bits a frame
		wr(BDV, 8'h01);
		wr(TXC, 8'h20);
		wr(SPC_OFF_TX_DATA, 8'h3C);
		rc(TXC, 8'h20);
		u_spc_line_partner.recv(128, rb);
		chk(32'(rb), 32'h0000_013C);
		rc(TXC, 8'h20);
		repeat (100) @(posedge aclk);
		rc(TXC, 8'h22);
		// sync master, divisor 1: 8 clocks a bit, one character from the idle-high line
		wr(TXC, 8'h90);
		wr(RXC, 8'hA0);
		@(negedge aclk);
		chk(32'(ck_oe_n), 32'h0);
		repeat (100) @(posedge aclk);
		rc(RXC, 8'h80);
		rc(RXD, 8'hFF);
		chk(32'(ck_o), 32'h0);
		// sync send: data pin driven only while shifting
		wr(TXC, 8'hB0);
		wr(SPC_OFF_TX_DATA, 8'h01);
		@(negedge aclk);
		chk(32'(dt_oe_n), 32'h0);
		chk(32'(dt_o), 32'h1);
		repeat (100) @(posedge aclk);
		rc(TXC, 8'hB2);
		chk(32'(dt_oe_n), 32'h1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
